// [design/wakeup_timer_pkg.sv]
package wakeup_timer_pkg;

    // Register indexes as printed; the byte address on APB is four times the index.
    localparam logic [7:0] IDX_EXPONENT   = 8'h14;  // Wake-up exponent, 5 bits.
    localparam logic [7:0] IDX_MANT_HIGH  = 8'h15;  // Period mantissa, high byte.
    localparam logic [7:0] IDX_MANT_LOW   = 8'h16;  // Period mantissa, low byte.
    localparam logic [7:0] IDX_COUNT_HIGH = 8'h17;  // Running mantissa count, high byte.
    localparam logic [7:0] IDX_COUNT_LOW  = 8'h18;  // Running mantissa count, low byte.
    localparam logic [7:0] IDX_DUTY       = 8'h19;  // On-window length.
    localparam logic [7:0] IDX_CONTROL    = 8'h08;  // Enables.
    localparam logic [7:0] IDX_STATUS     = 8'h09;  // Sticky events, write one to clear.
    localparam logic [7:0] IDX_MASK       = 8'h0a;  // Interrupt mask, same layout as status.

    // Field positions.
    localparam int CTRL_WAKE_EN_BIT  = 0;  // Wake-up timer enable.
    localparam int CTRL_LDC_EN_BIT   = 1;  // Low-duty-cycle enable.
    localparam int STAT_WAKE_BIT     = 0;  // A wake-up period expired.
    localparam int STAT_LDC_DONE_BIT = 1;  // An on-window closed.
    localparam int EXP_W             = 5;  // Exponent width.
    localparam int MANT_W            = 16; // Mantissa width.
    localparam int PRESC_W           = 22; // Holds four times two to the twentieth, minus one.

    // Reset values.
    localparam logic [4:0] EXP_RESET       = 5'h03;
    localparam logic [7:0] MANT_HIGH_RESET = 8'h00;
    localparam logic [7:0] MANT_LOW_RESET  = 8'h01;
    localparam logic [7:0] DUTY_RESET      = 8'h01;

    // Timing figures.
    localparam logic [4:0] EXP_MAX        = 5'h14;  // Largest effective exponent, twenty.
    localparam int         LF_STEP_TICKS  = 4;      // Timebase ticks per mantissa step at R=0.
    localparam int         LF_HZ_DEFAULT  = 32768;  // Low-frequency timebase, 32.768 kHz.
    localparam int         CORE_PERIOD_NS = 4;      // Core clock period in ns.
    localparam int         CORE_HZ        = 1000000000 / CORE_PERIOD_NS;
    localparam int         ACC_W          = 28;     // Phase accumulator, holds CORE_HZ.

    // Timer sequencing.
    typedef enum logic [0:0] {
        TMR_IDLE = 1'b0,
        TMR_RUN  = 1'b1
    } tmr_state_t;

endpackage

// [design/lf_tick_if.sv]
`timescale 1ns/10ps
// Carries the low-frequency timebase strobe from its generator to the timer.
interface lf_tick_if;
    logic tick;  // One core cycle high per timebase period.

    modport gen  (output tick);
    modport user (input tick);
endinterface

// [design/lf_tick_gen.sv]
`timescale 1ns/10ps
// Makes the 32.768 kHz timebase from the core clock with a phase accumulator.
module lf_tick_gen
    import wakeup_timer_pkg::*;
#(
    parameter int LF_HZ = LF_HZ_DEFAULT
) (
    input  wire logic core_clk,
    input  wire logic srst,
    lf_tick_if.gen    lf
);

    // All state of the generator.
    typedef struct packed {
        logic [ACC_W-1:0] acc;   // Fractional phase, counts LF_HZ per core cycle.
        logic             tick;  // Registered strobe.
    } gen_state_t;

    localparam logic [ACC_W-1:0] STEP  = ACC_W'(LF_HZ);
    localparam logic [ACC_W-1:0] LIMIT = ACC_W'(CORE_HZ);

    gen_state_t cur;  // Present state.
    gen_state_t nxt;  // Next state.

    // A fractional divider keeps the average rate exact; each tick jitters by one cycle,
    // which is far below the timebase period.
    always_comb begin
        logic [ACC_W:0] sum;
        sum      = {1'b0, cur.acc} + {1'b0, STEP};
        nxt      = cur;
        nxt.tick = 1'b0;
        if (sum >= {1'b0, LIMIT}) begin
            nxt.acc  = ACC_W'(sum - {1'b0, LIMIT});
            nxt.tick = 1'b1;
        end else begin
            nxt.acc = sum[ACC_W-1:0];
        end
        if (srst) begin
            nxt = '0;
        end
    end

    // State register.
    always_ff @(posedge core_clk) begin
        cur <= nxt;
    end

    assign lf.tick = cur.tick;

endmodule // lf_tick_gen

// [design/wakeup_timer_low_duty_cycle.sv]
`timescale 1ns/10ps
// Overview of operation
// - Period is four M times two-to-R ticks.
// - Mantissa in two RW bytes; high resets zero.
// - Running count readable as two RO bytes.
// - On-window starts with each wake-up period.
// - Window is four duty times two-to-R ticks if duty is below M.
// - Exponent clamps at twenty; zero allowed.
module wakeup_timer_low_duty_cycle
    import wakeup_timer_pkg::*;
#(
    parameter int LF_HZ = LF_HZ_DEFAULT  // Timebase rate; raise it to shorten simulation.
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             wake_pulse,
    output logic             ldc_window
);

    // One packed struct keeps reset and register in one place.
    // All state of the timer and its register file.
    typedef struct packed {
        logic [1:0]         ctrl;       // Enables.
        logic [EXP_W-1:0]   exponent;   // Exponent as written.
        logic [7:0]         mant_high;  // Mantissa high byte.
        logic [7:0]         mant_low;   // Mantissa low byte.
        logic [7:0]         duty;       // On-window length in mantissa steps.
        logic [1:0]         status;     // Sticky events.
        logic [1:0]         mask;       // Interrupt enables.
        tmr_state_t         state;      // Idle or running.
        logic [PRESC_W-1:0] presc;      // Timebase ticks within one mantissa step.
        logic [MANT_W-1:0]  mant_cnt;   // Remaining mantissa steps in this period.
        logic [7:0]         ldc_left;   // Remaining mantissa steps in the on-window.
        logic               window;     // On-window open.
        logic               wake;       // One-cycle wake-up strobe.
        logic [31:0]        rdata;      // Read data captured in the setup phase.
        logic               err;        // Unmapped address seen in the setup phase.
    } core_state_t;

    core_state_t cur;  // Present state.
    core_state_t nxt;  // Next state.

    // A real slow oscillator can replace the generator
    // behind this interface without touching the timer.
    lf_tick_if lf ();  // Timebase strobe.

    // Timebase generator.
    lf_tick_gen #(
        .LF_HZ (LF_HZ)
    ) u_tick (
        .core_clk (core_clk),
        .srst     (srst),
        .lf       (lf.gen)
    );

    // One aligned word per register: byte address is four times the index.
    // Misaligned or high addresses match no case item.
    // Register index of an address, or an out-of-range marker when bits above or below it are set.
    function automatic logic [8:0] reg_index(input logic [11:0] addr);
        return (addr[11:10] == 2'h0 && addr[1:0] == 2'h0) ? {1'b0, addr[9:2]} : 9'h100;
    endfunction

    // Read-back shows the exponent as written; only timing is clamped.
    // Exponent as the counter sees it: values beyond twenty behave as twenty.
    function automatic logic [EXP_W-1:0] clamp_exp(input logic [EXP_W-1:0] e);
        return (e > EXP_MAX) ? EXP_MAX : e;
    endfunction

    // Decoded settings and strobes shared by the sequence and the checks.
    logic [EXP_W-1:0]   exp_eff;     // Effective exponent.
    logic [PRESC_W-1:0] presc_last;  // Last prescaler value of a mantissa step.
    logic [MANT_W-1:0]  mantissa;    // Programmed mantissa.
    logic [PRESC_W:0]   presc_span;  // Ticks per mantissa step, one bit wider.
    logic [8:0]         index;       // Decoded register index.
    logic               wr_access;   // A write completes this cycle.
    logic               step_end;    // A mantissa step ends this cycle.
    logic               expire;      // A wake-up period ends this cycle.
    logic               ldc_close;   // The on-window closes this cycle.

    // The step spans four times two to the exponent timebase ticks.
    // At exponent twenty the span needs one bit more than
    // the prescaler, so it is formed wider, then reduced.
    assign exp_eff    = clamp_exp(cur.exponent);
    assign presc_span = (PRESC_W + 1)'(LF_STEP_TICKS) << exp_eff;
    assign presc_last = PRESC_W'(presc_span - (PRESC_W + 1)'(1));
    assign mantissa   = {cur.mant_high, cur.mant_low};
    assign index      = reg_index(paddr);
    assign wr_access  = psel && penable && pwrite && pstrb[0] && !cur.err;

    // Steps end only on a tick, so a period is a whole
    // number of ticks; the core clock adds no drift.
    // A zero mantissa is forbidden to software; treating it as one keeps the counter sane.
    assign step_end  = (cur.state == TMR_RUN) && cur.ctrl[CTRL_WAKE_EN_BIT] && lf.tick
                       && (cur.presc == presc_last);
    assign expire    = step_end && (cur.mant_cnt <= MANT_W'(1));
    assign ldc_close = step_end && !expire && (cur.ldc_left == 8'h01);

    // Next-state logic: register file, APB capture and the timer sequence.
    always_comb begin
        logic [1:0] events;
        logic [1:0] clr;
        events = {ldc_close, expire};
        clr    = 2'h0;
        nxt    = cur;
        nxt.wake = expire;

        // Setup phase: decode and capture read data so prdata comes from flip-flops.
        // The word stands until the next setup, so a count
        // byte read is a snapshot from the setup cycle.
        if (psel && !penable) begin
            nxt.err   = 1'b0;
            nxt.rdata = 32'h0;
            unique case (index)
                {1'b0, IDX_EXPONENT}:   nxt.rdata[EXP_W-1:0] = cur.exponent;
                {1'b0, IDX_MANT_HIGH}:  nxt.rdata[7:0] = cur.mant_high;
                {1'b0, IDX_MANT_LOW}:   nxt.rdata[7:0] = cur.mant_low;
                {1'b0, IDX_COUNT_HIGH}: nxt.rdata[7:0] = cur.mant_cnt[15:8];
                {1'b0, IDX_COUNT_LOW}:  nxt.rdata[7:0] = cur.mant_cnt[7:0];
                {1'b0, IDX_DUTY}:       nxt.rdata[7:0] = cur.duty;
                {1'b0, IDX_CONTROL}:    nxt.rdata[1:0] = cur.ctrl;
                {1'b0, IDX_STATUS}:     nxt.rdata[1:0] = cur.status;
                {1'b0, IDX_MASK}:       nxt.rdata[1:0] = cur.mask;
                default:                nxt.err = 1'b1;
            endcase
        end

        // Access phase of a write; the count bytes ignore writes.
        // A refused address or a cleared lane zero strobe
        // leaves every register as it was.
        if (wr_access) begin
            unique case (index)
                {1'b0, IDX_EXPONENT}:  nxt.exponent = pwdata[EXP_W-1:0];
                {1'b0, IDX_MANT_HIGH}: nxt.mant_high = pwdata[7:0];
                {1'b0, IDX_MANT_LOW}:  nxt.mant_low = pwdata[7:0];
                {1'b0, IDX_DUTY}:      nxt.duty = pwdata[7:0];
                {1'b0, IDX_CONTROL}:   nxt.ctrl = pwdata[1:0];
                {1'b0, IDX_STATUS}:    clr = pwdata[1:0];
                {1'b0, IDX_MASK}:      nxt.mask = pwdata[1:0];
                default:               nxt.ctrl = cur.ctrl;
            endcase
        end

        // An event in the same cycle as its clear stays set.
        // So software never loses an event that arrived
        // while its clearing write was in flight.
        nxt.status = (cur.status & ~clr) | events;

        // Timer sequence. Settings are taken live, so software stops the timer
        // before changing them to avoid a period built from mixed values.
        unique case (cur.state)
            TMR_IDLE: begin
                // Start a fresh period from a clean prescaler.
                // The window opens with it when enabled, which
                // keeps both counters aligned from the first step.
                if (cur.ctrl[CTRL_WAKE_EN_BIT]) begin
                    nxt.state    = TMR_RUN;
                    nxt.presc    = '0;
                    nxt.mant_cnt = mantissa;
                    nxt.ldc_left = cur.ctrl[CTRL_LDC_EN_BIT] ? cur.duty : 8'h00;
                    nxt.window   = cur.ctrl[CTRL_LDC_EN_BIT] && (cur.duty != 8'h00);
                end
            end
            TMR_RUN: begin
                if (!cur.ctrl[CTRL_WAKE_EN_BIT]) begin
                    // Clearing the step phase keeps the prescaler
                    // within a smaller exponent written while idle.
                    nxt.state    = TMR_IDLE;
                    nxt.presc    = '0;
                    nxt.ldc_left = 8'h00;
                    nxt.window   = 1'b0;
                end else if (lf.tick) begin
                    nxt.presc = step_end ? '0 : PRESC_W'(cur.presc + PRESC_W'(1));
                    if (expire) begin
                        // New period: reload and reopen the on-window together.
                        nxt.mant_cnt = mantissa;
                        nxt.ldc_left = cur.ctrl[CTRL_LDC_EN_BIT] ? cur.duty : 8'h00;
                        nxt.window   = cur.ctrl[CTRL_LDC_EN_BIT] && (cur.duty != 8'h00);
                    end else if (step_end) begin
                        // One step done: count down, shorten the window.
                        nxt.mant_cnt = MANT_W'(cur.mant_cnt - MANT_W'(1));
                        if (cur.ldc_left != 8'h00) begin
                            nxt.ldc_left = 8'(cur.ldc_left - 8'h01);
                        end
                        if (ldc_close) begin
                            nxt.window = 1'b0;
                        end
                    end
                end
            end
        endcase

        // Synchronous reset; undefined resets get a usable value of one.
        // Placed last so it overrides every branch above,
        // a bus write in the same cycle included.
        if (srst) begin
            nxt           = '0;
            nxt.exponent  = EXP_RESET;
            nxt.mant_high = MANT_HIGH_RESET;
            nxt.mant_low  = MANT_LOW_RESET;
            nxt.duty      = DUTY_RESET;
        end
    end

    // State register.
    // All state, reset included, passes through here.
    always_ff @(posedge core_clk) begin
        cur <= nxt;
    end

    // Handshake outputs are combinational; prdata, wake_pulse
    // and ldc_window come from flip-flops and never glitch;
    // irq is a gate of the registered status and mask.
    // Zero-wait slave: the access phase always completes in its first cycle.
    assign pready     = psel && penable;
    assign pslverr    = psel && penable && cur.err;
    assign prdata     = cur.rdata;
    assign irq        = |(cur.status & cur.mask);
    assign wake_pulse = cur.wake;
    assign ldc_window = cur.window;

    // Checks kept beside the logic they guard.
    // These are silent during reset; the reset check is
    // the only one that looks at the cycle after it.
    chk_exp_clamp: assert property (@(posedge core_clk) disable iff (srst)
        (cur.exponent > EXP_MAX) |-> (exp_eff == EXP_MAX && presc_last == 22'h3fffff))
        else $error("Exponent above twenty not clamped.");

    chk_presc_bound: assert property (@(posedge core_clk) disable iff (srst)
        cur.presc <= presc_last)
        else $error("Prescaler ran past its step length.");

    chk_period_reload: assert property (@(posedge core_clk) disable iff (srst)
        (expire && !$changed(mantissa)) |=> (cur.mant_cnt == $past(mantissa) && cur.wake))
        else $error("Counter not reloaded at period end.");

    chk_window_start: assert property (@(posedge core_clk) disable iff (srst)
        (expire && cur.ctrl[CTRL_LDC_EN_BIT] && cur.duty != 8'h00 && cur.ctrl[CTRL_WAKE_EN_BIT])
        |=> (ldc_window && cur.ldc_left == $past(cur.duty)))
        else $error("On-window did not open with the period.");

    chk_window_close: assert property (@(posedge core_clk) disable iff (srst)
        ldc_close |=> (!ldc_window && cur.ldc_left == 8'h00 && cur.status[STAT_LDC_DONE_BIT]))
        else $error("On-window did not close after its length.");

    chk_mant_reset: assert property (@(posedge core_clk)
        srst |=> (cur.mant_high == MANT_HIGH_RESET && !ldc_window && !irq))
        else $error("Mantissa high byte not reset to zero.");

    chk_count_read: assert property (@(posedge core_clk) disable iff (srst)
        (psel && !penable && !pwrite && index == {1'b0, IDX_COUNT_LOW})
        |=> (prdata == {24'h0, $past(cur.mant_cnt[7:0])}))
        else $error("Count low byte read wrong.");

    chk_sticky_set: assert property (@(posedge core_clk) disable iff (srst)
        expire |=> cur.status[STAT_WAKE_BIT]
            ##0 (irq == cur.mask[STAT_WAKE_BIT] || cur.status[STAT_LDC_DONE_BIT]))
        else $error("Wake-up event not latched.");

    chk_status_clear: assert property (@(posedge core_clk) disable iff (srst)
        (wr_access && index == {1'b0, IDX_STATUS} && pwdata[STAT_WAKE_BIT] && !expire)
        |=> !cur.status[STAT_WAKE_BIT])
        else $error("Wake-up status bit not cleared by a write of one.");

    chk_wake_single: assert property (@(posedge core_clk) disable iff (srst)
        wake_pulse |=> !wake_pulse)
        else $error("Wake-up pulse lasted more than one cycle.");

    chk_stop_clean: assert property (@(posedge core_clk) disable iff (srst)
        (cur.state == TMR_RUN && !cur.ctrl[CTRL_WAKE_EN_BIT])
        |=> (cur.state == TMR_IDLE && !ldc_window && cur.presc == '0))
        else $error("Stopped timer kept its window or step phase.");

    chk_count_range: assert property (@(posedge core_clk) disable iff (srst)
        (cur.state == TMR_RUN)
        |-> (cur.mant_cnt != '0 && cur.mant_cnt <= mantissa))
        else $error("Running count outside one to the mantissa.");

    chk_ldc_off: assert property (@(posedge core_clk) disable iff (srst)
        (expire && !cur.ctrl[CTRL_LDC_EN_BIT])
        |=> !ldc_window)
        else $error("On-window opened while disabled.");

    chk_unmapped_write: assert property (@(posedge core_clk) disable iff (srst)
        (psel && penable && pwrite && cur.err)
        |=> ($stable(mantissa) && $stable(cur.ctrl) && $stable(cur.duty)))
        else $error("Refused write changed a register.");

endmodule // wakeup_timer_low_duty_cycle

// [design/_unused_placeholder_removed.sv]
`timescale 1ns/10ps

// [testbench/wakeup_timer_low_duty_cycle_tb_top.sv]
`timescale 1ns/10ps
// Self-checking bench: registers over APB, period and on-window timing, events and irq.
module wakeup_timer_low_duty_cycle_tb_top;
    import wakeup_timer_pkg::*;

    // A fast timebase gives one tick every four core cycles, so runs stay short.
    localparam int FAST_LF_HZ = 62500000;
    localparam int CYC_TICK   = CORE_HZ / FAST_LF_HZ;
    localparam int WAIT_MAX   = 20000;

    logic        core_clk;    // Core clock, 250 MHz.
    logic        srst;        // Synchronous reset, active high.
    logic [11:0] paddr;       // APB byte address.
    logic        psel;        // APB select.
    logic        penable;     // APB access phase.
    logic        pwrite;      // APB direction.
    logic [31:0] pwdata;      // APB write data.
    logic [3:0]  pstrb;       // APB byte strobes.
    logic [31:0] prdata;      // APB read data.
    logic        pready;      // APB ready.
    logic        pslverr;     // APB error.
    logic        irq;         // Level interrupt.
    logic        wake_pulse;  // Period expiry pulse.
    logic        ldc_window;  // On-window level.
    int          fail_count;  // Mismatches seen.
    int          checks;      // Comparisons made.
    logic [31:0] rd;          // Data of the last APB read.
    logic        err;         // Error of the last APB transfer.

    wakeup_timer_low_duty_cycle #(.LF_HZ(FAST_LF_HZ)) dut (
        .core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .wake_pulse(wake_pulse), .ldc_window(ldc_window)
    );

    // Free-running core clock, 4 ns period.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("Counts: %0d mismatches in %0d comparisons", fail_count, checks);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares a value seen at the ports.
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Compares a cycle count measured by the bench.
    task automatic cmp_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            fail_count++;
            $display("unexpected count at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // A bounded wait ran out; the run cannot go on sensibly.
    task automatic timed_out;
        fail_count++;
        $display("unexpected hang at %0t: got %h, expected %h", $time, 0, 1);
        close_out();
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) timed_out();
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a register and compares the whole read word.
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        cmp_val(rd, exp);
    endtask

    // Counts cycles until the next wake-up pulse, bounded.
    task automatic wait_wake(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wake_pulse !== 1'b1 && n < WAIT_MAX);
        if (wake_pulse !== 1'b1) timed_out();
    endtask

    // Waits for the on-window to reach a level, bounded.
    task automatic wait_win(input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ldc_window !== lvl && n < WAIT_MAX);
        if (ldc_window !== lvl) timed_out();
    endtask

    // Stops the timer, then loads exponent, mantissa and on-window length.
    task automatic setup(input logic [7:0] r, input logic [7:0] mh, input logic [7:0] ml,
                         input logic [7:0] duty);
        apb(1'b1, IDX_CONTROL, 8'h00);
        apb(1'b1, IDX_EXPONENT, r);
        apb(1'b1, IDX_MANT_HIGH, mh);
        apb(1'b1, IDX_MANT_LOW, ml);
        apb(1'b1, IDX_DUTY, duty);
    endtask

    // Reset values, an unmapped index, read-back, and writes that must be ignored.
    task automatic reg_access;
        rdc(IDX_MANT_HIGH, 32'h00000000);
        rdc(IDX_EXPONENT, 32'h00000003);
        apb(1'b0, 8'h30, 8'h00);
        cmp_val({31'h0, err}, 32'h00000001);
        cmp_val(rd, 32'h00000000);
        apb(1'b1, 8'h30, 8'hff);
        cmp_val({31'h0, err}, 32'h00000001);
        apb(1'b1, IDX_MANT_HIGH, 8'ha5);
        rdc(IDX_MANT_HIGH, 32'h000000a5);
        apb(1'b1, IDX_MANT_LOW, 8'h5a);
        rdc(IDX_MANT_LOW, 32'h0000005a);
        apb(1'b1, IDX_EXPONENT, 8'h1f);
        rdc(IDX_EXPONENT, 32'h0000001f);
        pstrb <= 4'h0;
        apb(1'b1, IDX_DUTY, 8'h7e);
        pstrb <= 4'hf;
        rdc(IDX_DUTY, 32'h00000001);
        apb(1'b1, IDX_COUNT_LOW, 8'hff);
        apb(1'b0, IDX_COUNT_LOW, 8'h00);
        cmp_val({31'h0, rd == 32'h000000ff}, 32'h00000000);
    endtask

    // Measures one full period and reads the running count just after enable.
    task automatic period_case(input logic [7:0] r, input logic [7:0] mh, input logic [7:0] ml);
        int n;
        int m;
        m = {mh, ml};
        setup(r, mh, ml, 8'h01);
        apb(1'b1, IDX_CONTROL, 8'h01);
        repeat (3) @(posedge core_clk);
        rdc(IDX_COUNT_HIGH, {24'h0, mh});
        rdc(IDX_COUNT_LOW, {24'h0, ml});
        wait_wake(n);
        wait_wake(n);
        cmp_cnt(n, m * LF_STEP_TICKS * (1 << r) * CYC_TICK);
    endtask

    // The on-window opens with a period and lasts duty steps.
    task automatic window_case;
        int n;
        logic a;
        logic b;
        setup(8'h00, 8'h00, 8'h03, 8'h02);
        apb(1'b1, IDX_CONTROL, 8'h03);
        wait_wake(n);
        wait_win(1'b0);
        wait_win(1'b1);
        a = wake_pulse;
        n = 1;
        @(posedge core_clk);
        b = wake_pulse;
        while (ldc_window === 1'b1 && n < WAIT_MAX) begin
            n++;
            @(posedge core_clk);
        end
        cmp_val({31'h0, a | b}, 32'h00000001);
        cmp_cnt(n, 2 * LF_STEP_TICKS * CYC_TICK);
        apb(1'b0, IDX_STATUS, 8'h00);
        cmp_val({31'h0, rd[STAT_LDC_DONE_BIT]}, 32'h00000001);
        apb(1'b1, IDX_MASK, 8'h02);
        @(posedge core_clk);
        cmp_val({31'h0, irq}, 32'h00000001);
        apb(1'b1, IDX_MASK, 8'h00);
        apb(1'b1, IDX_CONTROL, 8'h00);
        repeat (3) @(posedge core_clk);
        cmp_val({31'h0, ldc_window}, 32'h00000000);
    endtask

    // Wake event sets status; irq follows the mask; writing one clears.
    task automatic irq_case;
        int n;
        setup(8'h00, 8'h00, 8'h02, 8'h01);
        apb(1'b1, IDX_STATUS, 8'h03);
        apb(1'b1, IDX_MASK, 8'h01);
        apb(1'b1, IDX_CONTROL, 8'h01);
        wait_wake(n);
        @(posedge core_clk);
        cmp_val({31'h0, irq}, 32'h00000001);
        apb(1'b1, IDX_CONTROL, 8'h00);
        apb(1'b1, IDX_STATUS, 8'h01);
        rdc(IDX_STATUS, 32'h00000000);
        cmp_val({31'h0, irq}, 32'h00000000);
        apb(1'b1, IDX_MASK, 8'h00);
        apb(1'b1, IDX_CONTROL, 8'h01);
        wait_wake(n);
        apb(1'b0, IDX_STATUS, 8'h00);
        cmp_val({31'h0, rd[STAT_WAKE_BIT]}, 32'h00000001);
        cmp_val({31'h0, irq}, 32'h00000000);
        apb(1'b1, IDX_CONTROL, 8'h00);
    endtask

    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial begin
        fail_count = 0;
        checks     = 0;
        srst       = 1'b1;
        paddr      = 12'h000;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        pwdata     = 32'h00000000;
        pstrb      = 4'hf;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        reg_access();
        period_case(8'h00, 8'h00, 8'h03);
        period_case(8'h01, 8'h00, 8'h02);
        period_case(8'h00, 8'h01, 8'h01);
        window_case();
        irq_case();
        close_out();
    end
endmodule  // wakeup_timer_low_duty_cycle_tb_top
